/* can_flags_consts.svh */
// offsets, field positions and reset values of the can control and status flag block
`ifndef CAN_FLAGS_CONSTS_SVH
`define CAN_FLAGS_CONSTS_SVH

`define OFS_CONTROL_STATUS_0 12'h000
`define OFS_INIT_CONTROL 12'h004
`define OFS_STAMP_COUNT 12'h008
`define OFS_LINE_STATE 12'h00C
`define OFS_IRQ_ENABLE 12'h010

`define BIT_FRAME_SEEN 7
`define BIT_RECEIVING 6
`define BIT_STOP_WAIT 5
`define BIT_SYNCED 4
`define BIT_STAMP_EN 3
`define BIT_WAKEUP_EN 2
`define BIT_OVERRUN 1
`define BIT_RBF 0

`define BIT_INIT_REQ 0
`define BIT_INIT_ACK 1

`define BIT_RX_IRQ_EN 0
`define BIT_ERR_IRQ_EN 1

`define FLD_RX_STATE_LO 0
`define FLD_TX_STATE_LO 2
`define BIT_BUS_OFF 4

`define RST_CONTROL_STATUS_0 8'h00
`define RST_INIT_CONTROL 2'h0
`define RST_IRQ_ENABLE 2'h0
`define RST_STAMP_COUNT 16'h0000

`define STAMP_BYTE_HI 4'hE
`define STAMP_BYTE_LO 4'hF
`define BUSOFF_LIMIT 9'h0FF
`define TX_STATE_BUSOFF 2'h3

`endif

/* can_flags_pkg.sv */
// types of the can control and status flag block
package can_flags_pkg;

	typedef enum logic [1:0] {RX_OK, RX_WARN, RX_ERR, RX_BUSOFF} rx_state_e;

	typedef struct packed {
		logic receiving;
		logic synced;
		logic frame_ok;
		logic msg_done;
		logic bit_tick;
		logic overrun;
		logic fifo_valid;
		logic [8:0] tx_err_count;
		logic [1:0] rx_err_state;
		logic [1:0] tx_err_state;
	} core_status_s;

	typedef struct packed {
		logic we;
		logic [3:0] byte_hi;
		logic [3:0] byte_lo;
		logic [15:0] value;
	} stamp_wr_s;

	typedef struct packed {
		logic frame_seen;
		logic stop_wait;
		logic stamp_en;
		logic wakeup_en;
		logic overrun;
		logic rbf;
		logic init_req;
		logic init_ack;
		logic rx_irq_en;
		logic err_irq_en;
		rx_state_e rx_state;
		logic bus_off;
		logic sleep;
		logic wake_armed;
		logic wake_req;
		logic [15:0] stamp_cnt;
		stamp_wr_s stamp_wr;
		logic [31:0] prdata;
	} state_s;

endpackage : can_flags_pkg

/* can_control_status_flags.sv */
// control and status flag logic of a can controller with an apb register slave
//
// Summary of operation
// - valid frame sets frame-seen flag, write-one clears
// - receiving bit mirrors receiver activity, read-only
// - stop-in-wait gates bus interface clock in wait
// - synchronized bit tracks bus sync, read-only
// - stamp enable runs 16-bit bit-rate counter
// - after valid frame write stamp to top bytes
// - disabled stamp counter held at zero
// - stamp enable forced low in init mode
// - wake-up enable, latched at sleep entry, wakes on traffic
// - control writes blocked in init, except init request
// - overrun sets flag, unmasked flag holds error interrupt
// - fifo shift to foreground sets buffer-full flag
// - buffer-full flag set blocks further fifo shifts
// - unmasked buffer-full flag holds receive interrupt
// - bus-off only when tx error count exceeds 255
// - leaving bus-off reports receiver ok at once
// - init mode when request and acknowledge both set
//
// The APB interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ns
`include "can_flags_consts.svh"

module can_control_status_flags (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic pready,
	output logic pslverr,
	output logic [31:0] prdata,
	input wire can_flags_pkg::core_status_s core,
	input wire logic wait_mode,
	input wire logic sleep_mode,
	input wire logic bus_activity,
	output logic fifo_shift,
	output can_flags_pkg::stamp_wr_s stamp_wr,
	output logic bus_clock_en,
	output logic wakeup_req,
	output logic init_mode,
	output logic stamp_en,
	output logic rx_irq,
	output logic err_irq
);

	////////////////////////////////////////////////////////////////////////////////
	// helpers

	function automatic logic hit(input logic [11:0] addr, input logic [11:0] ofs);
		hit = (addr[11:2] == ofs[11:2]);
	endfunction : hit

	function automatic logic w1c(input logic old, input logic set, input logic clr);
		w1c = set | (old & ~clr);
	endfunction : w1c

	////////////////////////////////////////////////////////////////////////////////
	// state and decode

	can_flags_pkg::state_s s_q;
	can_flags_pkg::state_s s_d;
	logic mapped;
	logic setup;
	logic wr;
	logic wr_ctrl;
	logic wr_init;
	logic wr_irq;
	logic in_init;
	logic bus_off_now;
	logic shift;
	logic [7:0] ctrl_rd;
	logic [31:0] rd;

	assign mapped = hit(paddr, `OFS_CONTROL_STATUS_0) | hit(paddr, `OFS_INIT_CONTROL)
		| hit(paddr, `OFS_STAMP_COUNT) | hit(paddr, `OFS_LINE_STATE) | hit(paddr, `OFS_IRQ_ENABLE);
	assign setup = psel & ~penable;
	assign wr = psel & penable & pwrite & mapped & pstrb[0];
	assign in_init = s_q.init_req & s_q.init_ack;
	assign wr_ctrl = wr & hit(paddr, `OFS_CONTROL_STATUS_0) & ~in_init;
	assign wr_init = wr & hit(paddr, `OFS_INIT_CONTROL);
	assign wr_irq = wr & hit(paddr, `OFS_IRQ_ENABLE) & ~in_init;
	assign bus_off_now = core.tx_err_count > `BUSOFF_LIMIT;
	assign shift = ce & core.fifo_valid & ~s_q.rbf;

	////////////////////////////////////////////////////////////////////////////////
	// read data

	always_comb begin
		ctrl_rd = `RST_CONTROL_STATUS_0;
		ctrl_rd[`BIT_FRAME_SEEN] = s_q.frame_seen;
		ctrl_rd[`BIT_RECEIVING] = core.receiving;
		ctrl_rd[`BIT_STOP_WAIT] = s_q.stop_wait;
		ctrl_rd[`BIT_SYNCED] = core.synced;
		ctrl_rd[`BIT_STAMP_EN] = s_q.stamp_en;
		ctrl_rd[`BIT_WAKEUP_EN] = s_q.wakeup_en;
		ctrl_rd[`BIT_OVERRUN] = s_q.overrun;
		ctrl_rd[`BIT_RBF] = s_q.rbf;
		rd = 32'h00000000;
		if (hit(paddr, `OFS_CONTROL_STATUS_0)) begin
			rd[7:0] = ctrl_rd;
		end else if (hit(paddr, `OFS_INIT_CONTROL)) begin
			rd[`BIT_INIT_REQ] = s_q.init_req;
			rd[`BIT_INIT_ACK] = s_q.init_ack;
		end else if (hit(paddr, `OFS_STAMP_COUNT)) begin
			rd[15:0] = s_q.stamp_cnt;
		end else if (hit(paddr, `OFS_LINE_STATE)) begin
			rd[`FLD_RX_STATE_LO +: 2] = s_q.rx_state;
			rd[`FLD_TX_STATE_LO +: 2] = s_q.bus_off ? `TX_STATE_BUSOFF : core.tx_err_state;
			rd[`BIT_BUS_OFF] = s_q.bus_off;
		end else if (hit(paddr, `OFS_IRQ_ENABLE)) begin
			rd[`BIT_RX_IRQ_EN] = s_q.rx_irq_en;
			rd[`BIT_ERR_IRQ_EN] = s_q.err_irq_en;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		s_d = s_q;

		// read data is captured in the setup cycle, answered in the access cycle
		if (setup) begin
			s_d.prdata = rd;
		end

		// init handshake: acknowledge follows request one cycle later
		if (wr_init) begin
			s_d.init_req = pwdata[`BIT_INIT_REQ];
		end
		s_d.init_ack = s_q.init_req;

		// control writes
		if (wr_ctrl) begin
			s_d.stop_wait = pwdata[`BIT_STOP_WAIT];
			s_d.stamp_en = pwdata[`BIT_STAMP_EN];
			s_d.wakeup_en = pwdata[`BIT_WAKEUP_EN];
		end
		if (in_init) begin
			s_d.stamp_en = 1'b0;
		end
		if (wr_irq) begin
			s_d.rx_irq_en = pwdata[`BIT_RX_IRQ_EN];
			s_d.err_irq_en = pwdata[`BIT_ERR_IRQ_EN];
		end

		// sticky flags
		s_d.frame_seen = w1c(s_q.frame_seen, core.frame_ok, wr_ctrl & pwdata[`BIT_FRAME_SEEN]);
		s_d.overrun = w1c(s_q.overrun, core.overrun, wr_ctrl & pwdata[`BIT_OVERRUN]);
		s_d.rbf = w1c(s_q.rbf, shift, wr_ctrl & pwdata[`BIT_RBF]);

		// time stamp counter
		if (!s_q.stamp_en) begin
			s_d.stamp_cnt = `RST_STAMP_COUNT;
		end else if (core.bit_tick) begin
			s_d.stamp_cnt = 16'(s_q.stamp_cnt + 16'h0001);
		end
		s_d.stamp_wr.we = s_q.stamp_en & core.msg_done;
		s_d.stamp_wr.byte_hi = `STAMP_BYTE_HI;
		s_d.stamp_wr.byte_lo = `STAMP_BYTE_LO;
		if (s_q.stamp_en & core.msg_done) begin
			s_d.stamp_wr.value = s_q.stamp_cnt;
		end

		// bus-off and reported receiver state
		s_d.bus_off = bus_off_now;
		if (bus_off_now) begin
			s_d.rx_state = can_flags_pkg::RX_BUSOFF;
		end else if (s_q.bus_off) begin
			s_d.rx_state = can_flags_pkg::RX_OK;
		end else begin
			s_d.rx_state = can_flags_pkg::rx_state_e'(core.rx_err_state);
		end

		// wake-up: enable is sampled on sleep entry
		s_d.sleep = sleep_mode;
		if (sleep_mode & ~s_q.sleep) begin
			s_d.wake_armed = s_q.wakeup_en;
		end else if (!sleep_mode) begin
			s_d.wake_armed = 1'b0;
		end
		s_d.wake_req = sleep_mode & s_q.wake_armed & bus_activity;
	end

	////////////////////////////////////////////////////////////////////////////////
	// state register

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '0;
		end else if (ce) begin
			s_q <= s_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// outputs

	assign pready = 1'b1;
	assign pslverr = psel & penable & ~mapped;
	assign prdata = s_q.prdata;
	assign fifo_shift = shift;
	assign stamp_wr = s_q.stamp_wr;
	assign bus_clock_en = ~(wait_mode & s_q.stop_wait);
	assign wakeup_req = s_q.wake_req;
	assign init_mode = in_init;
	assign stamp_en = s_q.stamp_en;
	assign rx_irq = s_q.rbf & s_q.rx_irq_en;
	assign err_irq = s_q.overrun & s_q.err_irq_en;

endmodule : can_control_status_flags

/* can_flags_chk.sv */
// assertions on the ports of the can flag block
`timescale 1ns/1ns
module can_flags_chk (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire can_flags_pkg::core_status_s core,
	input wire logic wait_mode,
	input wire logic sleep_mode,
	input wire logic bus_activity,
	input wire logic fifo_shift,
	input wire can_flags_pkg::stamp_wr_s stamp_wr,
	input wire logic bus_clock_en,
	input wire logic wakeup_req,
	input wire logic init_mode,
	input wire logic stamp_en,
	input wire logic rx_irq
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	shift_gate_a: assert property (fifo_shift |-> core.fifo_valid && ce) else $error("shift gate");
	shift_block_a: assert property (fifo_shift |=> !fifo_shift) else $error("double shift");
	full_block_a: assert property (rx_irq |-> !fifo_shift) else $error("shift while full");
	stamp_write_a: assert property (stamp_en && ce && core.msg_done ##1 stamp_en |-> stamp_wr.we)
		else $error("no stamp");
	stamp_bytes_a: assert property (stamp_wr.we |-> stamp_wr.byte_hi == 4'hE && stamp_wr.byte_lo == 4'hF)
		else $error("stamp bytes");
	stamp_cause_a: assert property (stamp_wr.we |-> $past(core.msg_done) || !$past(ce)) else $error("stray stamp");
	init_stamp_a: assert property (init_mode && ce |=> !stamp_en) else $error("stamp in init");
	clk_stop_a: assert property (!bus_clock_en |-> wait_mode) else $error("clock stop");
	wake_cause_a: assert property (wakeup_req |-> $past(sleep_mode && bus_activity) || !$past(ce))
		else $error("wake");
	cover property (fifo_shift);
	cover property (stamp_wr.we);
	cover property (wakeup_req);
	cover property (!bus_clock_en);
endmodule : can_flags_chk
bind can_control_status_flags can_flags_chk chk (.*);

/* can_core_model.sv */
// behavioural can receiver core feeding the flag block
`timescale 1ns/1ns
module can_core_model (
	input wire logic pclk,
	input wire logic send,
	input wire logic fifo_shift,
	input wire logic [8:0] tec,
	output can_flags_pkg::core_status_s core
);
	int cnt = 0;
	initial core = '0;
	always @(posedge pclk) begin
		cnt <= cnt + 1;
		core.bit_tick <= (cnt % 4 == 0);
		core.synced <= 1'b1;
		core.receiving <= send;
		core.frame_ok <= send;
		core.msg_done <= send;
		core.overrun <= send && core.fifo_valid && !fifo_shift;
		core.fifo_valid <= send || (core.fifo_valid && !fifo_shift);
		core.tx_err_count <= tec;
	end
endmodule : can_core_model

/* tb_top.sv */
// self-checking bench for the can flag block
`timescale 1ns/1ns
module tb_top;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, send = 0;
	logic wait_mode = 0, sleep_mode = 0, bus_activity = 0, pready, pslverr, fifo_shift;
	logic bus_clock_en, wakeup_req, init_mode, stamp_en, rx_irq, err_irq;
	logic [11:0] paddr = 0;
	logic [8:0] tec = 0;
	logic [15:0] stamp_ref = 16'h0000, stamp_exp = 16'h0000;
	logic [31:0] pwdata = 0, prdata;
	logic [32:0] exp_q[$];
	int err_count = 0, checks = 0, cyc = 0;
	can_flags_pkg::core_status_s core;
	can_flags_pkg::stamp_wr_s stamp_wr;
	can_core_model bus (.pclk(pclk), .send(send), .fifo_shift(fifo_shift), .tec(tec), .core(core));
	can_control_status_flags dut (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .pready(pready), .pslverr(pslverr),
		.prdata(prdata), .core(core), .wait_mode(wait_mode), .sleep_mode(sleep_mode), .bus_activity(bus_activity),
		.fifo_shift(fifo_shift), .stamp_wr(stamp_wr), .bus_clock_en(bus_clock_en), .wakeup_req(wakeup_req),
		.init_mode(init_mode), .stamp_en(stamp_en), .rx_irq(rx_irq), .err_irq(err_irq));
	initial forever #50 pclk = ~pclk;
	always @(posedge pclk) begin
		if (stamp_en !== 1'b1) begin
			stamp_ref <= 16'h0000;
		end else if (core.bit_tick) begin
			stamp_ref <= stamp_ref + 16'h0001;
		end
		if (stamp_en && core.msg_done) begin
			stamp_exp <= stamp_ref;
		end
	end
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : end_of_test
	task automatic chk(input string n, input logic [32:0] s, input logic [32:0] e);
		checks++;
		if (s !== e) begin
			err_count++;
			$display("BAD %s exp %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic w = 1'b1);
		repeat (2) @(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : wr
	task automatic rd(input logic [11:0] a, input logic [32:0] e);
		exp_q.push_back(e);
		wr(a, 32'h0, 1'b0);
	endtask : rd
	task automatic frm();
		@(posedge pclk);
		send <= 1'b1;
		@(posedge pclk);
		send <= 1'b0;
	endtask : frm
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 3000) begin
			err_count++;
			end_of_test();
		end
	end
	always @(posedge pclk) if (psel && penable && pready && !pwrite) chk("prdata", {pslverr, prdata}, exp_q.pop_front());
	initial begin
		void'($urandom(32'ha22e121c));
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		rd(12'h000, 33'h10);
		rd(12'h008, 33'h0);
		rd(12'hFFC, 33'h100000000);
		wr(12'h010, $urandom | 32'h3);
		rd(12'h010, 33'h3);
		$display("registers done");
		frm();
		frm();
		frm();
		rd(12'h000, 33'h93);
		chk("irq", {rx_irq, err_irq}, 2'b11);
		wr(12'h000, 32'h0);
		rd(12'h000, 33'h93);
		wr(12'h000, 32'h83);
		rd(12'h000, 33'h11);
		chk("irq", {rx_irq, err_irq}, 2'b10);
		wr(12'h000, 32'h1);
		rd(12'h000, 33'h10);
		$display("flags done");
		wr(12'h004, 32'h1);
		rd(12'h004, 33'h3);
		wr(12'h000, 32'h28);
		wr(12'h010, 32'h0);
		rd(12'h000, 33'h10);
		rd(12'h010, 33'h3);
		wr(12'h004, 32'h0);
		wr(12'h000, 32'h08);
		@(negedge pclk);
		chk("stamp_en", stamp_en, 1'b1);
		repeat (12) @(posedge pclk);
		frm();
		for (int i = 0; i < 20 && stamp_wr.we !== 1'b1; i++) @(negedge pclk);
		chk("stamp", {stamp_wr.we, stamp_wr.byte_hi, stamp_wr.byte_lo}, 9'h1EF);
		chk("stamp_value", stamp_wr.value, stamp_exp);
		wr(12'h000, 32'h81);
		rd(12'h008, 33'h0);
		$display("init and stamp done");
		tec <= 9'h0FF;
		rd(12'h00C, 33'h0);
		tec <= 9'h100;
		rd(12'h00C, 33'h1F);
		tec <= 9'h000;
		rd(12'h00C, 33'h0);
		$display("bus-off done");
		wr(12'h000, 32'h20);
		wait_mode <= 1'b1;
		@(negedge pclk);
		chk("clock_en", bus_clock_en, 1'b0);
		wr(12'h000, 32'h04);
		@(negedge pclk);
		chk("clock_en", bus_clock_en, 1'b1);
		@(posedge pclk);
		wait_mode <= 1'b0;
		sleep_mode <= 1'b1;
		repeat ($urandom_range(5, 1)) @(posedge pclk);
		bus_activity <= 1'b1;
		repeat (2) @(negedge pclk);
		chk("wakeup", wakeup_req, 1'b1);
		$display("power modes done");
		end_of_test();
	end
endmodule : tb_top
